/* File: logic/svwd_consts.svh */
/*
  Timing and encoding constants for the supervisor watchdog block.
  Assumes a single 20 MHz clock and a 1 ms timebase tick derived from it.
*/
`ifndef SVWD_CONSTS_SVH
`define SVWD_CONSTS_SVH

// System clock rate in MHz
`define SVWD_CLK_MHZ 20
// Timebase tick length in ns (1 ms)
`define SVWD_TICK_NS 1000000
// Reset stretch after any cause ends, in ms
`define SVWD_STRETCH_MS 250
// Watchdog periods in ms per period_select setting
`define SVWD_WD_LOW_MS 150
`define SVWD_WD_OPEN_MS 600
`define SVWD_WD_HIGH_MS 1200
// Manual reset must stay low this many ms to qualify
`define SVWD_PB_QUAL_MS 4
// Width of the millisecond counters
`define SVWD_MS_W 11
// Supply-low lag in ns, the longest allowed
`define SVWD_SUPPLY_LAG_NS 8000

`endif

/* File: logic/svwd_pkg.sv */
/*
  Types for the supervisor watchdog block.
  Assumes the constants header is included by the design files.
*/
package svwd_pkg;

  // Encoding of the three-level period select pin
  typedef enum logic [1:0] {
    SVWD_PER_LOW = 2'h0,
    SVWD_PER_OPEN = 2'h1,
    SVWD_PER_HIGH = 2'h2
  } svwd_period_t;

  // Supervisor sequencing states
  typedef enum logic [1:0] {
    SVWD_RUN,
    SVWD_HOLD,
    SVWD_STRETCH
  } svwd_state_t;

endpackage

/* File: logic/svwd_db_if.sv */
/*
  Carrier between the supervisor top and its manual reset debouncer.
  Assumes both ends share the top's clock and synchronised reset.
*/
`timescale 1ns/1ps
`default_nettype none

interface svwd_db_if;
  logic tick;       // 1 ms timebase enable
  logic raw_n;      // Manual reset pin level, low = pressed
  logic pressed;    // Qualified press, level

  modport top (output tick, output raw_n, input pressed);
  modport deb (input tick, input raw_n, output pressed);
endinterface

`default_nettype wire

/* File: logic/svwd_debounce.sv */
/*
  Debouncer for the active-low manual reset input.
  Assumes the pin is synchronous to the clock and a 1 ms tick is supplied.
*/
`timescale 1ns/1ps
`default_nettype none

`include "svwd_consts.svh"

module svwd_debounce #(
  parameter int unsigned QUAL_MS = `SVWD_PB_QUAL_MS  // Low time to qualify, ms
) (
  input wire logic clk,      // System clock
  input wire logic rst_n,    // Synchronised reset, active low
  svwd_db_if.deb db          // Tick, raw pin and qualified press
);
  import svwd_pkg::*;

  // Refuse a threshold the counter cannot reach, or one too short to filter 1 ms glitches
  initial begin
    if (QUAL_MS < 2 || QUAL_MS >= (1 << `SVWD_MS_W)) begin
      $error("QUAL_MS out of range");
    end
  end

  logic [`SVWD_MS_W-1:0] low_ms_ff, nxt_low_ms;  // Whole ms seen low so far
  logic pressed_ff, nxt_pressed;                 // Qualified press

  // Next state: count ticks while low, restart on any high sample
  always_comb begin
    nxt_low_ms = low_ms_ff;
    nxt_pressed = pressed_ff;
    if (db.raw_n) begin
      // Release ends the press at once so the stretch starts promptly
      nxt_low_ms = '0;
      nxt_pressed = 1'b0;
    end else if (db.tick && !pressed_ff) begin
      // glitch rejection
      // A short low never spans enough whole ticks to qualify
      nxt_low_ms = low_ms_ff + `SVWD_MS_W'(1);
      if (low_ms_ff + `SVWD_MS_W'(1) >= `SVWD_MS_W'(QUAL_MS)) begin
        nxt_pressed = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_ms_ff <= '0;
      pressed_ff <= 1'b0;
    end else begin
      low_ms_ff <= nxt_low_ms;
      pressed_ff <= nxt_pressed;
    end
  end

  assign db.pressed = pressed_ff;

endmodule

`default_nettype wire

/* File: logic/svwd_top.sv */
/*
  Microprocessor supervisor: supply-low reset, watchdog and manual reset,
  each followed by a fixed reset stretch, on two opposite-polarity outputs.
  Assumes all inputs but RST_N are synchronous to MCLK; the analog comparators live
  outside and present one supply-low level per threshold margin.
*/
`timescale 1ns/1ps
`default_nettype none

`include "svwd_consts.svh"

module svwd_top #(
  parameter int unsigned TICK_CYCLES = `SVWD_TICK_NS * `SVWD_CLK_MHZ / 1000,  // Cycles per ms
  parameter int unsigned STRETCH_MS = `SVWD_STRETCH_MS,  // Reset stretch, ms
  parameter int unsigned WD_LOW_MS = `SVWD_WD_LOW_MS,    // Period, select low
  parameter int unsigned WD_OPEN_MS = `SVWD_WD_OPEN_MS,  // Period, select open
  parameter int unsigned WD_HIGH_MS = `SVWD_WD_HIGH_MS,  // Period, select high
  parameter int unsigned PB_QUAL_MS = `SVWD_PB_QUAL_MS   // Manual reset qualify time
) (
  input wire logic MCLK,                   // 20 MHz clock
  input wire logic RST_N,                  // Async reset, active low
  input wire logic SUPPLY_LOW_5PCT,        // Comparator: below 5% threshold
  input wire logic SUPPLY_LOW_10PCT,       // Comparator: below 10% threshold
  input wire logic THRESHOLD_MARGIN_SEL,   // 0 = 5% margin, 1 = 10% margin
  input wire svwd_pkg::svwd_period_t PERIOD_SELECT,  // Watchdog period select
  input wire logic WATCHDOG_KICK_N,        // Kick, falling edge restarts
  input wire logic MANUAL_RESET_N,         // Manual reset, active low
  output logic RESET,                      // Reset, active high
  output logic RESET_N,                    // Reset level, active low
  output logic RESET_N_DRV,                // Open-drain data, always low
  output logic RESET_N_OE_N                // Open-drain enable, low drives
);
  import svwd_pkg::*;

  // Supply-low must show within 8 us; one register stage is far inside that
  localparam int unsigned SUPPLY_LAG_CYC = `SVWD_SUPPLY_LAG_NS * `SVWD_CLK_MHZ / 1000;

  // Refuse zero lengths except WD_HIGH_MS and values the counters cannot hold; of the periods only WD_HIGH_MS has its upper bound checked
  initial begin
    if (TICK_CYCLES < 2 || SUPPLY_LAG_CYC < 2) begin
      $error("TICK_CYCLES or clock too small");
    end
    if (STRETCH_MS == 0 || STRETCH_MS >= (1 << `SVWD_MS_W)) begin
      $error("STRETCH_MS out of range");
    end
    if (WD_LOW_MS == 0 || WD_OPEN_MS == 0 || WD_HIGH_MS >= (1 << `SVWD_MS_W)) begin
      $error("Watchdog period out of range");
    end
  end

  // Watchdog period for a select code; high-code default covers the unused code
  function automatic logic [`SVWD_MS_W-1:0] wd_period(input svwd_period_t sel);
    logic [`SVWD_MS_W-1:0] ms;
    ms = `SVWD_MS_W'(WD_HIGH_MS);
    unique case (sel)
      SVWD_PER_LOW: ms = `SVWD_MS_W'(WD_LOW_MS);
      SVWD_PER_OPEN: ms = `SVWD_MS_W'(WD_OPEN_MS);
      SVWD_PER_HIGH: ms = `SVWD_MS_W'(WD_HIGH_MS);
      default: ms = `SVWD_MS_W'(WD_HIGH_MS);
    endcase
    return ms;
  endfunction

  // Reset release synchroniser: asserts at once, releases after two edges
  logic rst_meta_ff;  // First stage, read only by the second
  logic rst_sync_ff;  // Reset used by the rest of the design

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Timebase divider group
  logic [31:0] div_ff, nxt_div;  // Cycle count within the current ms
  logic tick;                    // One-cycle 1 ms enable

  always_comb begin
    tick = (div_ff == TICK_CYCLES - 1);
    nxt_div = tick ? 32'h0 : div_ff + 32'h1;
  end

  always_ff @(posedge MCLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      div_ff <= 32'h0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // Manual reset debouncer
  svwd_db_if db_if ();
  assign db_if.tick = tick;
  assign db_if.raw_n = MANUAL_RESET_N;

  svwd_debounce #(
    .QUAL_MS(PB_QUAL_MS)
  ) u_deb (
    .clk(MCLK),
    .rst_n(rst_sync_ff),
    .db(db_if)
  );

  // Supervisor group state
  svwd_state_t state_ff, nxt_state;        // Sequencing state
  logic [`SVWD_MS_W-1:0] stretch_ff, nxt_stretch;  // ms spent stretching
  logic [`SVWD_MS_W-1:0] wd_ff, nxt_wd;    // ms since last kick
  logic kick_prev_ff, nxt_kick_prev;       // Last kick level
  logic reset_ff, nxt_reset;               // Registered reset state
  logic supply_low;                        // Selected comparator
  logic kick_fall;                         // Kick falling edge this cycle
  logic hold_cause;                        // Level causes still present

  // Next state for the supervisor
  always_comb begin
    supply_low = THRESHOLD_MARGIN_SEL ? SUPPLY_LOW_10PCT : SUPPLY_LOW_5PCT;
    hold_cause = supply_low || db_if.pressed;
    kick_fall = kick_prev_ff && !WATCHDOG_KICK_N;
    nxt_kick_prev = WATCHDOG_KICK_N;
    nxt_state = state_ff;
    nxt_stretch = stretch_ff;
    nxt_wd = wd_ff;
    unique case (state_ff)
      SVWD_RUN: begin
        if (hold_cause) begin
          nxt_state = SVWD_HOLD;
          nxt_wd = '0;
        end else if (kick_fall) begin
          nxt_wd = '0;
        end else if (tick) begin
          if (wd_ff + `SVWD_MS_W'(1) >= wd_period(PERIOD_SELECT)) begin
            nxt_state = SVWD_STRETCH;
            nxt_stretch = '0;
            nxt_wd = '0;
          end else begin
            nxt_wd = wd_ff + `SVWD_MS_W'(1);
          end
        end
      end
      SVWD_HOLD: begin
        if (!hold_cause) begin
          nxt_state = SVWD_STRETCH;
          nxt_stretch = '0;
        end
      end
      SVWD_STRETCH: begin
        if (hold_cause) begin
          // A new cause during stretch restarts the whole sequence
          nxt_state = SVWD_HOLD;
        end else if (tick) begin
          // stretch length
          // One tick beyond the stretch length: the first tick after a cause
          // ends may come at once, so counting only that many could fall short
          if (stretch_ff >= `SVWD_MS_W'(STRETCH_MS)) begin
            nxt_state = SVWD_RUN;
          end else begin
            // Whole ms completed in this stretch
            nxt_stretch = stretch_ff + `SVWD_MS_W'(1);
          end
        end
      end
    endcase
    if (nxt_state != SVWD_RUN) begin
      nxt_wd = '0;
    end
    nxt_reset = (nxt_state != SVWD_RUN);
  end

  // Power-up enters a stretch so the processor starts from a full reset
  always_ff @(posedge MCLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= SVWD_STRETCH;
      stretch_ff <= '0;
      wd_ff <= '0;
      kick_prev_ff <= 1'b1;
      reset_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      stretch_ff <= nxt_stretch;
      wd_ff <= nxt_wd;
      kick_prev_ff <= nxt_kick_prev;
      reset_ff <= nxt_reset;
    end
  end

  assign RESET = reset_ff;
  assign RESET_N = ~reset_ff;
  assign RESET_N_DRV = 1'b0;
  assign RESET_N_OE_N = ~reset_ff;

endmodule

`default_nettype wire

/* File: test/svwd_asserts.sv */
/* Pin checker for svwd_top.
   Assumes binding to svwd_top with the bench timings. */
`timescale 1ns/1ps
`default_nettype none
module svwd_asserts #(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned STRETCH_MS = 5,
  parameter int unsigned WD_LOW_MS = 6,
  parameter int unsigned WD_OPEN_MS = 9,
  parameter int unsigned WD_HIGH_MS = 12,
  parameter int unsigned PB_QUAL_MS = 3
) (
  input wire logic MCLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic SUPPLY_LOW_5PCT, // Low 5%
  input wire logic SUPPLY_LOW_10PCT, // Low 10%
  input wire logic THRESHOLD_MARGIN_SEL, // Margin
  input wire svwd_pkg::svwd_period_t PERIOD_SELECT, // Period
  input wire logic WATCHDOG_KICK_N, // Kick
  input wire logic MANUAL_RESET_N, // Button
  input wire logic RESET, // Reset high
  input wire logic RESET_N, // Reset low
  input wire logic RESET_N_DRV, // Drain data
  input wire logic RESET_N_OE_N // Drain enable
);
  import svwd_pkg::*;
  localparam int T = TICK_CYCLES;
  localparam int SMIN = STRETCH_MS * T;
  localparam int SMAX = (STRETCH_MS + 1) * T + 4;
  localparam int QMIN = (PB_QUAL_MS - 1) * T - 2;
  localparam int QMAX = PB_QUAL_MS * T + 3;
  logic sel; // Selected comparator
  logic kq; // Kick last sample
  int per; // Period in ms
  int calm; // Held cycles, no cause
  int kc; // Cycles since kick
  int pl; // Cycles button low
  assign sel = THRESHOLD_MARGIN_SEL ? SUPPLY_LOW_10PCT : SUPPLY_LOW_5PCT;
  assign per = PERIOD_SELECT == SVWD_PER_LOW ? int'(WD_LOW_MS) :
               PERIOD_SELECT == SVWD_PER_OPEN ? int'(WD_OPEN_MS) : int'(WD_HIGH_MS);
  // Counters; a short button tap in a stretch would upset calm
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      calm <= 0;
      kc <= 0;
      pl <= 0;
      kq <= 1'b1;
    end else begin
      calm <= (!RESET || sel || !MANUAL_RESET_N) ? 0 : calm + 1;
      kc <= (RESET || (kq && !WATCHDOG_KICK_N)) ? 0 : kc + 1;
      pl <= MANUAL_RESET_N ? 0 : pl + 1;
      kq <= WATCHDOG_KICK_N;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_rel;
    sel ##1 !sel;
  endsequence
  property p_pol;
    RESET_N == !RESET;
  endproperty
  a_pol: assert property (p_pol) else $error("Outputs not inverse");
  property p_drain;
    RESET_N_OE_N == !RESET && !RESET_N_DRV;
  endproperty
  a_drain: assert property (p_drain) else $error("Drain pin wrong");
  property p_sup;
    sel |=> RESET;
  endproperty
  a_sup: assert property (p_sup) else $error("Supply low missed");
  property p_hold;
    s_rel |=> RESET [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("No hold after supply");
  property p_smin;
    $fell(RESET) |-> calm >= SMIN;
  endproperty
  a_smin: assert property (p_smin) else $error("Stretch short");
  property p_smax;
    RESET |-> calm <= SMAX;
  endproperty
  a_smax: assert property (p_smax) else $error("Stretch long");
  property p_wdmax;
    !RESET |-> kc <= per * T + 3;
  endproperty
  a_wdmax: assert property (p_wdmax) else $error("Watchdog late");
  property p_cause;
    $rose(RESET) |-> $past(sel) || pl >= QMIN || kc >= (per - 1) * T;
  endproperty
  a_cause: assert property (p_cause) else $error("Reset without cause");
  property p_pbl;
    pl == QMAX |-> RESET;
  endproperty
  a_pbl: assert property (p_pbl) else $error("Button reset late");
endmodule
bind svwd_top svwd_asserts #(.TICK_CYCLES(TICK_CYCLES), .STRETCH_MS(STRETCH_MS),
  .WD_LOW_MS(WD_LOW_MS), .WD_OPEN_MS(WD_OPEN_MS), .WD_HIGH_MS(WD_HIGH_MS),
  .PB_QUAL_MS(PB_QUAL_MS)) u_chk (.MCLK(MCLK), .RST_N(RST_N),
  .SUPPLY_LOW_5PCT(SUPPLY_LOW_5PCT), .SUPPLY_LOW_10PCT(SUPPLY_LOW_10PCT),
  .THRESHOLD_MARGIN_SEL(THRESHOLD_MARGIN_SEL), .PERIOD_SELECT(PERIOD_SELECT),
  .WATCHDOG_KICK_N(WATCHDOG_KICK_N), .MANUAL_RESET_N(MANUAL_RESET_N),
  .RESET(RESET), .RESET_N(RESET_N), .RESET_N_DRV(RESET_N_DRV),
  .RESET_N_OE_N(RESET_N_OE_N));
`default_nettype wire

/* File: test/svwd_cpu.sv */
/* Processor model that kicks the watchdog.
   Assumes a pulled-up reset wire; held in reset, it stays quiet. */
`timescale 1ns/1ps
`default_nettype none
module svwd_cpu (
  input wire logic clk, // Clock
  input wire logic rst_line, // Reset wire
  input wire logic en, // Kicking on
  input wire logic [7:0] gap, // Kick spacing
  output logic kick_n // Kick pin
);
  int n; // Cycles since kick
  initial begin
    kick_n = 1'b1;
    n = 0;
    forever begin
      @(negedge clk);
      n = (en && rst_line && n < gap) ? n + 1 : 0;
      kick_n = (n != gap);
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_supervisor_watchdog_reset.sv */
/* Bench for svwd_top with short timings.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
module tb_supervisor_watchdog_reset;
  import svwd_pkg::*;
  localparam int T = 10;
  localparam int S = 5;
  localparam int Q = 3;
  localparam int SLO = S * T; // Shortest legal stretch, cycles
  localparam int SHI = (S + 1) * T + 4; // Longest stretch plus sync and tick alignment
  logic mclk, rst_n_in, lo5, lo10, msel, pb_n, en, rst, rst_n, drv, oe_n, kick_n;
  svwd_period_t psel; // Period code
  logic [7:0] gap; // Kick spacing
  wire logic line = oe_n ? 1'b1 : drv; // Pulled-up wire
  int miscompares, cmp_count, c;
  int per[4] = '{6, 9, 12, 12}; // Period model
  svwd_top #(.TICK_CYCLES(T), .STRETCH_MS(S), .WD_LOW_MS(6), .WD_OPEN_MS(9),
    .WD_HIGH_MS(12), .PB_QUAL_MS(Q)) dut (.MCLK(mclk), .RST_N(rst_n_in),
    .SUPPLY_LOW_5PCT(lo5), .SUPPLY_LOW_10PCT(lo10), .THRESHOLD_MARGIN_SEL(msel),
    .PERIOD_SELECT(psel), .WATCHDOG_KICK_N(kick_n), .MANUAL_RESET_N(pb_n),
    .RESET(rst), .RESET_N(rst_n), .RESET_N_DRV(drv), .RESET_N_OE_N(oe_n));
  svwd_cpu u_cpu (.clk(mclk), .rst_line(line), .en(en), .gap(gap), .kick_n(kick_n));
  // Compare and count
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  // Cycles until reset reaches v, capped
  task automatic wait_r(input logic v, output int n);
    n = 0;
    while (rst !== v && n < 3000) begin
      @(negedge mclk);
      n++;
    end
  endtask
  function automatic logic in_rng(int n, int lo, int hi);
    return n >= lo && n <= hi;
  endfunction
  task automatic results();
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    results();
  end
  initial begin
    {rst_n_in, lo5, lo10, msel, pb_n, en} = 6'h02;
    psel = SVWD_PER_LOW;
    gap = 8'h14;
    miscompares = 0;
    cmp_count = 0;
    void'($urandom(32'h7659));
    repeat (5) @(negedge mclk);
    rst_n_in = 1'b1;
    wait_r(1'b0, c);
    check(in_rng(c, SLO, SHI), 1);
    check({rst, rst_n, oe_n}, 4'h3);
    $display("Test power-up done");
    // Expiry for every period code, kicks off
    for (int p = 0; p < 4; p++) begin
      lo5 = 1'b1;
      repeat (2) @(negedge mclk);
      check(rst, 1);
      psel = svwd_period_t'(p);
      lo5 = 1'b0;
      wait_r(1'b0, c);
      check(in_rng(c, SLO, SHI), 1);
      wait_r(1'b1, c);
      check(in_rng(c, (per[p] - 1) * T, per[p] * T + 3), 1);
      wait_r(1'b0, c);
      check(in_rng(c, SLO, SHI), 1);
    end
    $display("Test watchdog done");
    en = 1'b1;
    for (int m = 0; m < 2; m++) begin
      msel = m[0];
      gap = 8'(5 + $urandom % 30);
      repeat (150) @(negedge mclk);
      check(rst, 0);
      {lo10, lo5} = m[0] ? 2'h1 : 2'h2;
      repeat (20) @(negedge mclk);
      check(rst, 0);
      {lo10, lo5} = m[0] ? 2'h2 : 2'h1;
      repeat (2) @(negedge mclk);
      check(rst, 1);
      {lo10, lo5} = 2'h0;
      wait_r(1'b0, c);
      check(in_rng(c, SLO, SHI), 1);
    end
    $display("Test margin done");
    pb_n = 1'b0;
    repeat (1 + $urandom % (T - 1)) @(negedge mclk);
    pb_n = 1'b1;
    repeat (3 * T) @(negedge mclk);
    check(rst, 0);
    pb_n = 1'b0;
    wait_r(1'b1, c);
    check(in_rng(c, (Q - 1) * T - 2, Q * T + 3), 1);
    repeat (T) @(negedge mclk);
    pb_n = 1'b1;
    wait_r(1'b0, c);
    check(in_rng(c, SLO, SHI), 1);
    rst_n_in = 1'b0;
    @(negedge mclk);
    check(rst, 1);
    rst_n_in = 1'b1;
    wait_r(1'b0, c);
    check(in_rng(c, SLO, SHI), 1);
    $display("Test button done");
    results();
  end
endmodule
`default_nettype wire
